// File: core/nvc_pkg.sv
// Shared constants and types for the host-side nonvolatile SRAM controller
package nvc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int ADDR_W    = 15;
   localparam int DATA_W    = 8;
   localparam int MEM_BYTES = 32768;     // 2**ADDR_W bytes
   localparam int MATCH_W   = 14;        // Address bits the device compares
   localparam int CNT_W     = 19;        // Wide enough for the store wait

   ////////////////////////////////////////////////////////////////////////////
   // Times as printed, then in ref_clk cycles
   localparam int CLK_PERIOD_NS = 25;    // ref_clk at 40 MHz
   localparam int STROBE_NS     = 30;    // Chip select low width, slow grade
   localparam int ACCESS_NS     = 45;    // Chip select access, slow grade
   localparam int CYCLE_NS      = 45;    // Initiation cycle time, slow grade
   localparam int REQ_PULSE_NS  = 20;    // request_pulse_width
   localparam int BUSY_NS       = 300;   // request_to_busy_time
   localparam int RECOVER_NS    = 700;   // Pin high to inhibit off
   localparam int RECALL_US     = 20;
   localparam int RESTORE_US    = 550;
   localparam int STORE_MS      = 10;

   // Least times round up, longest times round down
   localparam int STROBE_CYC  = (((STROBE_NS > ACCESS_NS) ? STROBE_NS : ACCESS_NS)
                                 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_CYC   = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_PULSE_CYC = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CYC    = BUSY_NS / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = RECOVER_NS / CLK_PERIOD_NS;
   localparam int RECALL_CYC  = (RECALL_US * 1000) / CLK_PERIOD_NS;
   localparam int RESTORE_CYC = (RESTORE_US * 1000) / CLK_PERIOD_NS;
   localparam int STORE_CYC   = (STORE_MS * 1000000) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Unlock sequence addresses
   localparam logic [ADDR_W-1:0] SEQ_ADDR_0      = 15'h0e38;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_1      = 15'h31c7;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_2      = 15'h03e0;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_3      = 15'h3c1f;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_4      = 15'h303f;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_STORE  = 15'h0fc0;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_RECALL = 15'h0c63;
   localparam logic [2:0]        SEQ_LAST        = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      NVC_CMD_READ      = 3'h0,
      NVC_CMD_WRITE     = 3'h1,
      NVC_CMD_SW_STORE  = 3'h2,
      NVC_CMD_SW_RECALL = 3'h3,
      NVC_CMD_HW_STORE  = 3'h4
   } nvc_cmd_type;

   typedef struct packed {
      nvc_cmd_type         cmd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } nvc_req_type;

   typedef struct packed {
      logic                chip_sel_n;
      logic                write_n;
      logic                out_gate_n;
      logic [ADDR_W-1:0]   addr;
   } nvc_pins_type;

   localparam nvc_pins_type PINS_IDLE = '{chip_sel_n: 1'b1, write_n: 1'b1,
                                          out_gate_n: 1'b1, addr: 15'h0000};

   // Step address of the six-read sequence; top address bit always zero
   function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                  input logic       recall);
      logic [ADDR_W-1:0] a;
      a = SEQ_ADDR_0;
      unique case (idx)
         3'h0:    a = SEQ_ADDR_0;
         3'h1:    a = SEQ_ADDR_1;
         3'h2:    a = SEQ_ADDR_2;
         3'h3:    a = SEQ_ADDR_3;
         3'h4:    a = SEQ_ADDR_4;
         default: a = recall ? SEQ_ADDR_RECALL : SEQ_ADDR_STORE;
      endcase
      return a;
   endfunction

endpackage

// File: core/nvc_cycle.sv
// One chip-select-controlled read or write cycle on the memory pins
`timescale 1ns/1ps
module nvc_cycle (
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        start,
   input  wire logic                        is_write,
   input  wire logic [nvc_pkg::ADDR_W-1:0]  addr,
   input  wire logic [nvc_pkg::DATA_W-1:0]  wdata,
   input  wire logic [nvc_pkg::DATA_W-1:0]  data_in,
   output nvc_pkg::nvc_pins_type            pins,
   output logic      [nvc_pkg::DATA_W-1:0]  data_out,
   output logic                             data_oe,
   output logic      [nvc_pkg::DATA_W-1:0]  rdata,
   output logic                             done
);

   typedef enum logic [1:0] {
      CYC_IDLE   = 2'b00,
      CYC_SETUP  = 2'b01,
      CYC_STROBE = 2'b11,
      CYC_HOLD   = 2'b10
   } nvc_cyc_type;

   nvc_cyc_type state_q;
   logic [1:0]  cnt_q;
   logic        wr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sequencing: address first, strobe second, address held past release
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= CYC_IDLE;
         cnt_q   <= 2'h0;
         wr_q    <= 1'b0;
         pins    <= nvc_pkg::PINS_IDLE;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_q)
            CYC_IDLE: begin
               if (start) begin
                  state_q   <= CYC_SETUP;
                  wr_q      <= is_write;
                  pins.addr <= addr;
               end
            end
            CYC_SETUP: begin
               state_q         <= CYC_STROBE;
               cnt_q           <= 2'(nvc_pkg::STROBE_CYC - 1);
               pins.chip_sel_n <= 1'b0;
               pins.write_n    <= ~wr_q;
               pins.out_gate_n <= wr_q;
            end
            CYC_STROBE: begin
               if (cnt_q == 2'h0) begin
                  state_q         <= CYC_HOLD;
                  pins.chip_sel_n <= 1'b1;
                  pins.write_n    <= 1'b1;
                  pins.out_gate_n <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            CYC_HOLD: begin
               // Extra idle cycle keeps the next strobe off the cycle time
               state_q <= CYC_IDLE;
               done    <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data lanes: drive from setup to hold so data covers the strobe edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_out <= 8'h00;
         data_oe  <= 1'b0;
         rdata    <= 8'h00;
      end else begin
         if (state_q == CYC_IDLE && start) begin
            data_out <= wdata;
            data_oe  <= is_write;
         end else if (state_q == CYC_HOLD) begin
            data_oe  <= 1'b0;
         end
         // Sampled as the strobe rises, a full access time after it fell
         if (state_q == CYC_STROBE && cnt_q == 2'h0 && !wr_q) begin
            rdata <= data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the cycle shape
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_strobe_low;
      (!pins.chip_sel_n) [*2] ##1 pins.chip_sel_n;
   endsequence

   property p_addr_stable;
      !pins.chip_sel_n |=> $stable(pins.addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("address moved while chip select low");

   property p_gate_in_write;
      !pins.write_n |-> pins.out_gate_n && data_oe && !pins.chip_sel_n;
   endproperty
   a_gate_in_write: assert property (p_gate_in_write)
      else $error("output gate low or data undriven during write");

   property p_strobe_width;
      $fell(pins.chip_sel_n) |-> s_strobe_low;
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("chip select low width wrong");

   property p_cycle_gap;
      $rose(pins.chip_sel_n) |-> pins.chip_sel_n [*3];
   endproperty
   a_cycle_gap: assert property (p_cycle_gap)
      else $error("chip select high gap too short");

endmodule

// File: core/nvc_host.sv
// Host controller driving a nonvolatile SRAM through its pins
// Function
// - Host holds address stable through each write until select or strobe rises.
// - Host keeps output gate high during writes; device tristates anyway.
// - Six select-clocked reads 0E38,31C7,03E0,3C1F,303F,0FC0 start software store.
// - Same five then 0C63 starts recall, finished within 20 us.
// - Host keeps write strobe high through all six sequence cycles.
// - Store pin request held low at least 20 ns.
// - Sequence reads are select-controlled with cycle time at least 35/45 ns.
`timescale 1ns/1ps
module nvc_host #(
   parameter int unsigned STORE_CYCLES   = nvc_pkg::STORE_CYC,
   parameter int unsigned RESTORE_CYCLES = nvc_pkg::RESTORE_CYC
) (
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        cmd_valid,
   input  wire nvc_pkg::nvc_req_type        cmd_req,
   output logic                             cmd_ready,
   output logic                             cmd_done,
   output logic                             rsp_valid,
   output logic      [nvc_pkg::DATA_W-1:0]  rsp_rdata,
   output nvc_pkg::nvc_pins_type            mem_pins,
   input  wire logic [nvc_pkg::DATA_W-1:0]  data_pins_in,
   output logic      [nvc_pkg::DATA_W-1:0]  data_pins_out,
   output logic                             data_pins_oe,
   input  wire logic                        hw_store_busy_n_in,
   output logic                             hw_store_busy_n_out,
   output logic                             hw_store_busy_n_oe
);

   typedef enum logic [2:0] {
      ST_BOOT     = 3'b000,
      ST_IDLE     = 3'b001,
      ST_ACCESS   = 3'b011,
      ST_SEQ      = 3'b010,
      ST_NV_WAIT  = 3'b110,
      ST_HW_PULL  = 3'b111,
      ST_HW_WATCH = 3'b101,
      ST_RECOVER  = 3'b100
   } nvc_state_type;

   localparam int CW = nvc_pkg::CNT_W;

   nvc_state_type        state_q;
   logic [CW-1:0]        wait_q;
   logic [2:0]           seq_idx_q;
   logic                 recall_q;
   nvc_pkg::nvc_req_type req_q;
   logic                 issue_q;
   logic                 cyc_done;
   logic [7:0]           cyc_rdata;
   logic [14:0]          issue_addr;

   // Sequence steps never set the top address bit
   assign issue_addr = (state_q == ST_SEQ) ? nvc_pkg::seq_addr(seq_idx_q, recall_q)
                                           : req_q.addr;

   ////////////////////////////////////////////////////////////////////////////
   // Pin cycle engine
   nvc_cycle u_cycle (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .start    (issue_q),
      .is_write ((state_q == ST_ACCESS) && (req_q.cmd == nvc_pkg::NVC_CMD_WRITE)),
      .addr     (issue_addr),
      .wdata    (req_q.wdata),
      .data_in  (data_pins_in),
      .pins     (mem_pins),
      .data_out (data_pins_out),
      .data_oe  (data_pins_oe),
      .rdata    (cyc_rdata),
      .done     (cyc_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer; the device gets no access while it is busy or recovering
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q            <= ST_BOOT;
         wait_q             <= CW'(RESTORE_CYCLES - 1);
         seq_idx_q          <= 3'h0;
         recall_q           <= 1'b0;
         req_q              <= '0;
         issue_q            <= 1'b0;
         cmd_ready          <= 1'b0;
         hw_store_busy_n_oe <= 1'b0;
      end else begin
         issue_q <= 1'b0;
         unique case (state_q)
            ST_BOOT: begin
               // Power-up recall may still be running after our reset
               if (wait_q == '0) begin
                  state_q   <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end else begin
                  wait_q <= wait_q - CW'(1);
               end
            end
            ST_IDLE: begin
               if (!hw_store_busy_n_in) begin
                  // Device-started store: wait for the pin, then recover
                  state_q   <= ST_HW_WATCH;
                  wait_q    <= '0;
                  cmd_ready <= 1'b0;
               end else if (cmd_valid && cmd_ready) begin
                  req_q     <= cmd_req;
                  cmd_ready <= 1'b0;
                  unique case (cmd_req.cmd)
                     nvc_pkg::NVC_CMD_READ, nvc_pkg::NVC_CMD_WRITE: begin
                        state_q <= ST_ACCESS;
                        issue_q <= 1'b1;
                     end
                     nvc_pkg::NVC_CMD_SW_STORE, nvc_pkg::NVC_CMD_SW_RECALL: begin
                        state_q   <= ST_SEQ;
                        seq_idx_q <= 3'h0;
                        recall_q  <= (cmd_req.cmd == nvc_pkg::NVC_CMD_SW_RECALL);
                        issue_q   <= 1'b1;
                     end
                     default: begin
                        state_q            <= ST_HW_PULL;
                        wait_q             <= CW'(nvc_pkg::REQ_PULSE_CYC - 1);
                        hw_store_busy_n_oe <= 1'b1;
                     end
                  endcase
               end
            end
            ST_ACCESS: begin
               if (cyc_done) begin
                  state_q   <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            ST_SEQ: begin
               // Back-to-back reads only, nothing interleaved
               if (cyc_done) begin
                  if (seq_idx_q == nvc_pkg::SEQ_LAST) begin
                     state_q <= ST_NV_WAIT;
                     wait_q  <= recall_q ? CW'(nvc_pkg::RECALL_CYC - 1)
                                         : CW'(STORE_CYCLES - 1);
                  end else begin
                     seq_idx_q <= seq_idx_q + 3'h1;
                     issue_q   <= 1'b1;
                  end
               end
            end
            ST_NV_WAIT: begin
               if (wait_q == '0) begin
                  state_q   <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end else begin
                  wait_q <= wait_q - CW'(1);
               end
            end
            ST_HW_PULL: begin
               if (wait_q == '0) begin
                  state_q            <= ST_HW_WATCH;
                  wait_q             <= CW'(nvc_pkg::BUSY_CYC);
                  hw_store_busy_n_oe <= 1'b0;
               end else begin
                  wait_q <= wait_q - CW'(1);
               end
            end
            ST_HW_WATCH: begin
               // Give busy time to appear, then wait for the release
               if (wait_q != '0) begin
                  wait_q <= wait_q - CW'(1);
               end else if (hw_store_busy_n_in) begin
                  state_q <= ST_RECOVER;
                  wait_q  <= CW'(nvc_pkg::RECOVER_CYC - 1);
               end
            end
            ST_RECOVER: begin
               if (wait_q == '0) begin
                  state_q   <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end else begin
                  wait_q <= wait_q - CW'(1);
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain store pin only ever pulls low
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hw_store_busy_n_out <= 1'b0;
      end else begin
         hw_store_busy_n_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answers to the command port
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         cmd_done  <= 1'b0;
      end else begin
         rsp_valid <= cyc_done && state_q == ST_ACCESS &&
                      req_q.cmd == nvc_pkg::NVC_CMD_READ;
         rsp_rdata <= cyc_rdata;
         cmd_done  <= (state_q == ST_ACCESS && cyc_done) ||
                      (state_q != ST_IDLE && state_q != ST_BOOT &&
                       state_q != ST_ACCESS && state_q != ST_SEQ &&
                       state_q != ST_HW_PULL && state_q != ST_HW_WATCH &&
                       wait_q == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the host side of the protocol
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_pull_then_watch;
      (state_q == ST_HW_PULL && hw_store_busy_n_oe) ##1
      (state_q == ST_HW_WATCH && !hw_store_busy_n_oe);
   endsequence

   property p_seq_no_write;
      state_q == ST_SEQ |-> mem_pins.write_n && !data_pins_oe;
   endproperty
   a_seq_no_write: assert property (p_seq_no_write)
      else $error("write strobe or data driven inside sequence");

   property p_seq_top_bit;
      state_q == ST_SEQ && !mem_pins.chip_sel_n |-> mem_pins.addr[14] == 1'b0;
   endproperty
   a_seq_top_bit: assert property (p_seq_top_bit)
      else $error("top address bit set in sequence");

   property p_pull_width;
      $rose(hw_store_busy_n_oe) |-> s_pull_then_watch;
   endproperty
   a_pull_width: assert property (p_pull_width)
      else $error("store request pulse width wrong");

   property p_nv_quiet;
      state_q == ST_NV_WAIT || state_q == ST_HW_WATCH |-> mem_pins.chip_sel_n;
   endproperty
   a_nv_quiet: assert property (p_nv_quiet)
      else $error("access during nonvolatile cycle");

   property p_recover_load;
      state_q == ST_HW_WATCH && wait_q == '0 && hw_store_busy_n_in |=>
         state_q == ST_RECOVER && wait_q == 19'(nvc_pkg::RECOVER_CYC - 1);
   endproperty
   a_recover_load: assert property (p_recover_load)
      else $error("recovery wait not started");

   property p_seq_exit;
      state_q == ST_SEQ && cyc_done && seq_idx_q == 3'h5 && !recall_q |=>
         state_q == ST_NV_WAIT && wait_q == 19'(STORE_CYCLES - 1);
   endproperty
   a_seq_exit: assert property (p_seq_exit)
      else $error("store wait not loaded after sixth read");

endmodule

// File: verif/nvc_dev_model.sv
// Behavioural nonvolatile SRAM standing on the host pins
`timescale 1ns/1ps
module nvc_dev_model #(
   parameter int STORE_NS  = 600,
   parameter int RECALL_NS = 300
) (
   input  wire nvc_pkg::nvc_pins_type pins,
   input  wire logic [7:0]            host_data,
   input  wire logic                  busy_n,
   output logic      [7:0]            dev_data,
   output logic                       dev_pull
);
   localparam logic [13:0] SEQ [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
   logic [7:0] sram [0:32767];
   logic [7:0] nvm  [0:32767];
   logic [2:0] step    = 3'h0;
   logic       written = 1'b0;
   logic       nv_busy = 1'b0;
   logic       wr_cyc  = 1'b0;
   logic       cap_ok  = 1'b1;
   initial dev_pull = 1'b0;
   initial foreach (nvm[i]) begin
      nvm[i] = 8'h00;
      sram[i] = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Released data lines show an inverted pattern, never the last byte
   always @* begin
      if (!pins.chip_sel_n && !pins.out_gate_n && pins.write_n && busy_n && !nv_busy)
         dev_data = sram[pins.addr];
      else
         dev_data = ~sram[pins.addr];
   end
   // Host lifts select and write strobe in one step, so note the write early
   always @(negedge pins.chip_sel_n) wr_cyc = !pins.write_n;
   always @(negedge pins.write_n) begin
      if (!pins.chip_sel_n)
         wr_cyc = 1'b1;
   end
   // Copy SRAM to the shadow array while holding the busy pin low
   task automatic nv_store();
      dev_pull = 1'b1;
      #(STORE_NS);
      foreach (nvm[i]) nvm[i] = sram[i];
      written = 1'b0;
      dev_pull = 1'b0;
   endtask
   // Access ends on the rising select edge; only the read data path looks at the gate level
   always @(posedge pins.chip_sel_n) begin
      if (wr_cyc) begin
         // Writes are dropped while the store capacitor supply is low
         if (busy_n && !nv_busy && cap_ok) begin
            sram[pins.addr] = host_data;
            written = 1'b1;
         end
         step = 3'h0;
      end else if (busy_n && !nv_busy) begin
         if (step == 3'h5 && pins.addr[13:0] == 14'h0fc0) begin
            nv_busy = 1'b1;
            nv_store();
            nv_busy = 1'b0;
            step = 3'h0;
         end else if (step == 3'h5 && pins.addr[13:0] == 14'h0c63) begin
            nv_busy = 1'b1;
            #(RECALL_NS);
            foreach (sram[i]) sram[i] = nvm[i];
            written = 1'b0;
            nv_busy = 1'b0;
            step = 3'h0;
         end else if (step < 3'h5 && pins.addr[13:0] == SEQ[step]) step = step + 3'h1;
         else step = (pins.addr[13:0] == 14'h0e38) ? 3'h1 : 3'h0;
      end
   end
   // Pin request: stay disabled until the pin rises, store only if written
   always @(negedge busy_n) begin
      if (!nv_busy) begin
         nv_busy = 1'b1;
         #100;
         if (written) nv_store();
         wait (busy_n);
         nv_busy = 1'b0;
      end
   end
endmodule

// File: verif/nvc_host_tb.sv
// Self-checking bench for the host controller against the device model
`timescale 1ns/1ps
module nvc_host_tb;
   logic                  ref_clk   = 1'b0;
   logic                  sys_rst   = 1'b1;
   logic                  cmd_valid = 1'b0;
   logic                  tb_pull   = 1'b0;
   nvc_pkg::nvc_req_type  cmd_req   = '0;
   nvc_pkg::nvc_pins_type mem_pins;
   logic                  cmd_ready, cmd_done, rsp_valid, data_pins_oe, busy_out, busy_oe;
   logic                  dev_pull;
   logic [7:0]            rsp_rdata, data_pins_out, dev_data, got;
   int                    n_mismatch = 0;
   int                    compares   = 0;
   // Open-drain store pin and shared data lines
   wire logic       pin_n = !(busy_oe || dev_pull || tb_pull);
   wire logic [7:0] bus   = data_pins_oe ? data_pins_out : dev_data;
   always #12.5 ref_clk = ~ref_clk;
   nvc_host #(.STORE_CYCLES(50), .RESTORE_CYCLES(20)) dut (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_pins(mem_pins),
      .data_pins_in(bus), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
      .hw_store_busy_n_in(pin_n), .hw_store_busy_n_out(busy_out),
      .hw_store_busy_n_oe(busy_oe));
   nvc_dev_model dev (.pins(mem_pins), .host_data(data_pins_out), .busy_n(pin_n),
      .dev_data(dev_data), .dev_pull(dev_pull));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Bounded waits only; a hang ends the run as a failure
   task automatic tick(inout int i);
      @(negedge ref_clk);
      i++;
      if (i > 5000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   // One command: hold the request until taken, then wait for completion
   task automatic do_cmd(input nvc_pkg::nvc_cmd_type c, input logic [14:0] a,
                         input logic [7:0] d);
      int i;
      i = 0;
      @(negedge ref_clk);
      cmd_req = '{cmd: c, addr: a, wdata: d};
      cmd_valid = 1'b1;
      while (!(cmd_ready === 1'b1 && pin_n === 1'b1)) tick(i);
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      while (cmd_done !== 1'b1) tick(i);
      got = rsp_rdata;
      if (c == nvc_pkg::NVC_CMD_READ) check({7'h00, rsp_valid}, 8'h01);
   endtask
   // Boundary addresses written then read back
   task automatic t_rw();
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h7fff, 8'ha5);
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0000, 8'h5a);
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h7fff, 8'h00);
      check(got, 8'ha5);
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h0000, 8'h00);
      check(got, 8'h5a);
   endtask
   // Software store, overwrite, software recall restores the stored byte
   task automatic t_sw();
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0123, 8'h3c);
      do_cmd(nvc_pkg::NVC_CMD_SW_STORE, 15'h0000, 8'h00);
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0123, 8'hc3);
      do_cmd(nvc_pkg::NVC_CMD_SW_RECALL, 15'h0000, 8'h00);
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h0123, 8'h00);
      check(got, 8'h3c);
   endtask
   // Pin-requested store after a write, then recall proves it happened
   task automatic t_hw();
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0200, 8'h77);
      do_cmd(nvc_pkg::NVC_CMD_HW_STORE, 15'h0000, 8'h00);
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0200, 8'h88);
      do_cmd(nvc_pkg::NVC_CMD_SW_RECALL, 15'h0000, 8'h00);
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h0200, 8'h00);
      check(got, 8'h77);
   endtask
   // Far side holds the store pin low: host must not start a cycle
   task automatic t_dev();
      @(negedge ref_clk);
      tb_pull = 1'b1;
      repeat (40) @(negedge ref_clk);
      check({7'h00, cmd_ready}, 8'h00);
      check({7'h00, mem_pins.chip_sel_n}, 8'h01);
      check({7'h00, busy_out}, 8'h00);
      tb_pull = 1'b0;
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h0200, 8'h00);
      check(got, 8'h77);
      // Low capacitor supply: the device drops the write
      dev.cap_ok = 1'b0;
      do_cmd(nvc_pkg::NVC_CMD_WRITE, 15'h0200, 8'h99);
      dev.cap_ok = 1'b1;
      do_cmd(nvc_pkg::NVC_CMD_READ, 15'h0200, 8'h00);
      check(got, 8'h77);
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_rw();
      t_sw();
      t_hw();
      t_dev();
      end_of_test();
   end
endmodule
